//--- pkg/qdb_pkg.sv
// Purpose: shared constants and types of the quad dac double buffer core
// Assumes: 100 MHz core clock, 2-wire link sampled by core clock
// Notes:   data word layout is mode, clear, load, right-justified code
package qdb_pkg;
	localparam int          NUM_CH     = 4;
	localparam int          CODE_W     = 12;
	localparam int          MODE_W     = 2;
	// data word bit positions
	localparam int          BIT_MODE_HI = 15;
	localparam int          BIT_MODE_LO = 14;
	localparam int          BIT_CLR_N   = 13;
	localparam int          BIT_LD_N    = 12;
	// power mode encodings
	localparam logic [1:0]  MODE_NORMAL = 2'h0;
	localparam logic [1:0]  MODE_PD_1K  = 2'h1;
	localparam logic [1:0]  MODE_PD_100K = 2'h2;
	localparam logic [1:0]  MODE_PD_HIZ = 2'h3;
	// wake time from power-down, 5 V figure
	localparam real         WAKE_TIME_US = 2.5;
	localparam real         CLK_MHZ      = 100.0;
	localparam int          WAKE_CYC     = int'(WAKE_TIME_US * CLK_MHZ);
	localparam int          WAKE_W       = 9;
	// apb map, byte addresses
	localparam logic [7:0]  ADR_CMD    = 8'h00;
	localparam logic [7:0]  ADR_STATUS = 8'h04;
	localparam logic [7:0]  ADR_INPUT0 = 8'h10;
	localparam logic [7:0]  ADR_DAC0   = 8'h20;
	localparam int          CMD_SEL_LSB = 16;
	localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
	// 2-wire framing
	localparam int          BIT_CNT_W  = 4;
	localparam logic [3:0]  BITS_BYTE  = 4'h8;
	localparam logic [3:0]  BITS_ACK   = 4'h9;
	// slave address upper six bits; value is arbitrary
	localparam logic [5:0]  SLV_ADR_BASE = 6'h0C;

	typedef struct packed {
		logic [MODE_W-1:0] mode;
		logic              clr_n;
		logic              ld_n;
		logic [CODE_W-1:0] code;
	} qdb_word_t;

	typedef struct packed {
		logic [NUM_CH-1:0] sel;
		qdb_word_t         word;
	} qdb_cmd_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADR  = 6'b000010,
		ST_PTR  = 6'b000100,
		ST_MSB  = 6'b001000,
		ST_LSB  = 6'b010000,
		ST_SKIP = 6'b100000
	} qdb_state_t;
endpackage

//--- hw/qdb_core.sv
// Purpose: quad dac input/output registers, load control, power modes
// Assumes: scl and sda arrive asynchronous; two-flop synchronised here
// Notes:   readback over the link is not handled; apb shows command, status, input, code and mode state
// Contract
// R1: on write completion copy received code into each addressed input register.
// R2: load bit high keeps output-code registers unchanged.
// R3: load bit low moves input registers into output-code registers.
// R4: only channels written since their last load get updated.
// R5: mode bits are data word bits 15 and 14.
// R6: mode 00 normal, 01 1k load, 10 100k load, 11 high impedance.
// R7: power-down keeps output-code registers intact.
// R8: output resumes 2.5 us after eighth clock rise of the write.
// R9: master writes three channels load high, then the last load low.
// R10: address-select pin forms part of the slave address.
// R11: bit 13 active-low clear, bit 12 active-low load, then code msb first.
// R12: clear bit low zeroes all input and output-code registers.
// R13: one write reaches every channel selected in the pointer byte.
// R14: reset clears all registers and selects normal mode; the code resets act_r and the scl/sda synchroniser flops to 1.
`timescale 1ns/1ps
module qdb_core
	import qdb_pkg::*;
(
	input  wire logic                     CLOCK_I,
	input  wire logic                     RST_B_I,
	input  wire logic                     PSEL_I,
	input  wire logic                     PENABLE_I,
	input  wire logic                     PWRITE_I,
	input  wire logic [7:0]               PADDR_I,
	input  wire logic [31:0]              PWDATA_I,
	output logic      [31:0]              PRDATA_O,
	output logic                          PREADY_O,
	output logic                          PSLVERR_O,
	input  wire logic                     SCL_I,
	input  wire logic                     SDA_I,
	output logic                          SDA_O,
	output logic                          SDA_OE_O,
	input  wire logic                     ADDRESS_SELECT_PIN_I,
	output logic      [NUM_CH*CODE_W-1:0] DAC_CODE_O,
	output logic      [NUM_CH*MODE_W-1:0] POWER_MODE_O,
	output logic      [NUM_CH-1:0]        OUT_ACTIVE_O
);
	// synchronisers: first stage read only by second
	logic [1:0] scl_s_r, sda_s_r, asel_s_r;
	logic       scl_d_r, sda_d_r;
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			scl_s_r  <= 2'h3;
			sda_s_r  <= 2'h3;
			asel_s_r <= 2'h0;
			scl_d_r  <= 1'b1;
			sda_d_r  <= 1'b1;
		end else begin
			scl_s_r  <= {scl_s_r[0], SCL_I};
			sda_s_r  <= {sda_s_r[0], SDA_I};
			asel_s_r <= {asel_s_r[0], ADDRESS_SELECT_PIN_I};
			scl_d_r  <= scl_s_r[1];
			sda_d_r  <= sda_s_r[1];
		end
	end

	wire scl    = scl_s_r[1];
	wire sda    = sda_s_r[1];
	wire scl_rise = scl & ~scl_d_r;
	wire scl_fall = ~scl & scl_d_r;
	wire start_c  = scl & scl_d_r & sda_d_r & ~sda;
	wire stop_c   = scl & scl_d_r & ~sda_d_r & sda;

	// link receiver
	qdb_state_t           st_r, st_nxt;
	logic [BIT_CNT_W-1:0] bit_r;
	logic [7:0]           sh_r;
	logic [7:0]           msb_r;
	logic [NUM_CH-1:0]    ptr_r;
	logic                 ack_r;
	wire [7:0]            sh_in = {sh_r[6:0], sda};
	wire                  byte_done = scl_rise & (bit_r == BITS_BYTE - 4'h1);
	wire                  bit9_fall = scl_fall & (bit_r == BITS_ACK);
	// R10 address pin
	wire                  adr_hit = (sh_in[7:1] == {SLV_ADR_BASE, asel_s_r[1]}) & ~sh_in[0];
	// R8 commit on eighth rise of final byte
	wire                  link_commit = byte_done & (st_r == ST_LSB);

	always_comb begin
		st_nxt = st_r;
		if (byte_done) begin
			case (st_r)
				ST_ADR:  st_nxt = adr_hit ? ST_PTR : ST_SKIP;
				ST_PTR:  st_nxt = ST_MSB;
				ST_MSB:  st_nxt = ST_LSB;
				ST_LSB:  st_nxt = ST_MSB;
				ST_IDLE: st_nxt = ST_IDLE;
				ST_SKIP: st_nxt = ST_SKIP;
				default: st_nxt = ST_IDLE;
			endcase
		end
		if (start_c) begin
			st_nxt = ST_ADR;
		end else if (stop_c) begin
			st_nxt = ST_IDLE;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_r  <= ST_IDLE;
			bit_r <= '0;
			sh_r  <= 8'h00;
			msb_r <= 8'h00;
			ptr_r <= '0;
			ack_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (start_c || stop_c || bit9_fall) begin
				bit_r <= '0;
			end else if (scl_rise) begin
				bit_r <= bit_r + 4'h1;
			end
			if (scl_rise) begin
				sh_r <= sh_in;
			end
			if (byte_done && st_r == ST_PTR) begin
				ptr_r <= sh_in[NUM_CH-1:0];
			end
			if (byte_done && st_r == ST_MSB) begin
				msb_r <= sh_in;
			end
			// ack by pulling sda low through the ninth clock
			if (scl_fall && bit_r == BITS_BYTE) begin
				ack_r <= (st_r == ST_PTR) | (st_r == ST_MSB) | (st_r == ST_LSB);
			end else if (bit9_fall || start_c || stop_c) begin
				ack_r <= 1'b0;
			end
		end
	end

	// apb slave, no wait states
	logic              rdy_r, err_r;
	logic [31:0]       rd_r;
	qdb_cmd_t          apb_cmd_r;
	logic              apb_pend_r;
	logic [CODE_W-1:0] inp_r [NUM_CH];
	logic [CODE_W-1:0] dac_r [NUM_CH];
	logic [MODE_W-1:0] mode_r [NUM_CH];
	logic [NUM_CH-1:0] dirty_r, act_r;
	wire               setup_c  = PSEL_I & ~PENABLE_I;
	wire               access_c = PSEL_I & PENABLE_I & rdy_r;
	wire [1:0]         ch_idx   = PADDR_I[3:2];
	wire               is_inp   = (PADDR_I[7:4] == ADR_INPUT0[7:4]) & (PADDR_I[1:0] == 2'h0);
	wire               is_dac   = (PADDR_I[7:4] == ADR_DAC0[7:4]) & (PADDR_I[1:0] == 2'h0);
	wire               is_cmd   = PADDR_I == ADR_CMD;
	wire               is_stat  = PADDR_I == ADR_STATUS;
	wire               bad_adr  = ~(is_inp | is_dac | is_cmd | (is_stat & ~PWRITE_I));
	wire [31:0]        rd_mux   =
		is_cmd  ? {12'h000, apb_cmd_r} :
		is_stat ? {23'h000000, apb_pend_r, act_r, dirty_r} :
		is_inp  ? {20'h00000, inp_r[ch_idx]} :
		is_dac  ? {18'h00000, mode_r[ch_idx], dac_r[ch_idx]} : RD_ZERO;
	wire               apb_wr   = access_c & PWRITE_I & is_cmd;

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rdy_r <= 1'b0;
			err_r <= 1'b0;
			rd_r  <= RD_ZERO;
		end else begin
			rdy_r <= setup_c;
			err_r <= setup_c & bad_adr;
			rd_r  <= (setup_c & ~PWRITE_I) ? rd_mux : RD_ZERO;
		end
	end

	// a link commit takes the update slot; a software command waits one cycle
	wire       apb_go = apb_pend_r & ~link_commit;
	qdb_cmd_t  cmd;
	assign cmd.sel  = link_commit ? ptr_r : apb_cmd_r.sel;
	// R5 R11 word layout
	assign cmd.word = link_commit ? qdb_word_t'({msb_r, sh_in}) : apb_cmd_r.word;
	wire       commit = link_commit | apb_go;

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			apb_cmd_r  <= '0;
			apb_pend_r <= 1'b0;
		end else begin
			if (apb_wr) begin
				apb_cmd_r <= qdb_cmd_t'(PWDATA_I[CMD_SEL_LSB+NUM_CH-1:0]);
			end
			apb_pend_r <= apb_wr | (apb_pend_r & ~apb_go);
		end
	end

	// per-channel registers
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			// R13 pointer select
			wire                  hit  = commit & cmd.sel[g];
			// R4 only changed inputs load
			wire                  load = commit & ~cmd.word.ld_n & (dirty_r[g] | cmd.sel[g]);
			wire                  clr  = commit & ~cmd.word.clr_n;
			logic [WAKE_W-1:0]    wake_r;
			always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					// R14 reset state
					inp_r[g]   <= '0;
					dac_r[g]   <= '0;
					mode_r[g]  <= MODE_NORMAL;
					dirty_r[g] <= 1'b0;
					wake_r     <= '0;
					act_r[g]   <= 1'b1;
				end else begin
					if (clr) begin
						// R12 clear all
						inp_r[g]   <= '0;
						dac_r[g]   <= '0;
						dirty_r[g] <= 1'b0;
					end else begin
						// R1 input register
						if (hit) begin
							inp_r[g] <= cmd.word.code;
						end
						// R3 transfer; R2 hold when load bit high
						if (load) begin
							dac_r[g] <= hit ? cmd.word.code : inp_r[g];
						end
						dirty_r[g] <= load ? 1'b0 : (dirty_r[g] | hit);
					end
					// R6 R7 mode kept apart from codes
					if (hit) begin
						mode_r[g] <= cmd.word.mode;
					end
					// R8 wake delay after leaving power-down
					if (hit && cmd.word.mode == MODE_NORMAL && mode_r[g] != MODE_NORMAL) begin
						wake_r   <= WAKE_W'(WAKE_CYC);
						act_r[g] <= 1'b0;
					end else if (hit && cmd.word.mode != MODE_NORMAL) begin
						wake_r   <= '0;
						act_r[g] <= 1'b0;
					end else if (wake_r != '0) begin
						wake_r   <= wake_r - WAKE_W'(1);
						act_r[g] <= (wake_r == WAKE_W'(1));
					end
				end
			end
			assign DAC_CODE_O[g*CODE_W +: CODE_W]   = dac_r[g];
			assign POWER_MODE_O[g*MODE_W +: MODE_W] = mode_r[g];
		end
	endgenerate

	assign OUT_ACTIVE_O = act_r;
	assign PRDATA_O     = rd_r;
	assign PREADY_O     = rdy_r;
	assign PSLVERR_O    = err_r;
	assign SDA_O        = 1'b0;
	assign SDA_OE_O     = ack_r;
endmodule

//--- verification/qdb_assertions.sv
// Purpose: port-level checks of qdb_core
// Assumes: sees only the ports of qdb_core
// Notes:   wake window leaves slack for the input synchronisers
`timescale 1ns/1ps
module qdb_assertions
	import qdb_pkg::*;
(
	input wire logic        CLOCK_I,
	input wire logic        RST_B_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        SDA_OE_O,
	input wire logic [47:0] DAC_CODE_O,
	input wire logic [7:0]  POWER_MODE_O,
	input wire logic [3:0]  OUT_ACTIVE_O
);
	localparam int WK_LO = 245;
	localparam int WK_HI = 255;
	wire setup = PSEL_I && !PENABLE_I;
	wire bad = !(PADDR_I inside {ADR_CMD, ADR_STATUS, [8'h10:8'h2C]}) || (PADDR_I[1:0] != 2'h0)
		|| (PWRITE_I && PADDR_I == ADR_STATUS);
	wire pd1 = |POWER_MODE_O[3:2];
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	a_ready_next: assert property (setup |=> PREADY_O) else $error("ready missing");
	a_ready_once: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
	a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == RD_ZERO) else $error("stray rdata");
	a_err_decode: assert property (setup |=> PSLVERR_O == $past(bad)) else $error("bad slverr");
	a_ack_hold: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*4]) else $error("short ack");
	a_pd_quiet: assert property (pd1 |=> !OUT_ACTIVE_O[1]) else $error("active in pd");
	a_wake_time: assert property ($fell(pd1) |-> ##[WK_LO:WK_HI] $rose(OUT_ACTIVE_O[1]))
		else $error("wake time off");
	a_reset_vals: assert property ($rose(RST_B_I) |-> DAC_CODE_O == 48'h0
		&& POWER_MODE_O == 8'h00 && OUT_ACTIVE_O == 4'hF) else $error("bad reset state");
	c_wake: cover property ($fell(pd1));
	c_err: cover property (PSLVERR_O);
	c_ack: cover property ($rose(SDA_OE_O));
endmodule
bind qdb_core qdb_assertions u_chk (.*);

//--- verification/qdb_link_master.sv
// Purpose: 2-wire bus master writing to qdb_core
// Assumes: 80 ns scl period, sda open drain with pull-up
// Notes:   acks not demanded; the core acks the address byte only on a match
`timescale 1ns/1ps
module qdb_link_master
	import qdb_pkg::*;
(
	input  wire logic clk_i,
	output logic      scl_o = 1'b1,
	output logic      sda_o = 1'b1
);
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// sda moves only while scl low
	task automatic bit_out(input logic b);
		sda_o <= b;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		scl_o <= 1'b0;
		tick(2);
	endtask
	task automatic xfer(input logic a0, input logic [7:0] ptr, input logic [15:0] w);
		logic [31:0] f;
		f = {SLV_ADR_BASE, a0, 1'b0, ptr, w};
		sda_o <= 1'b0;
		tick(4);
		scl_o <= 1'b0;
		tick(2);
		for (int i = 31; i >= 0; i--) begin
			bit_out(f[i]);
			if (i % 8 == 0)
				bit_out(1'b1);
		end
		sda_o <= 1'b0;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b1;
		tick(4);
	endtask
endmodule

//--- verification/tb.sv
// Purpose: self-checking bench of qdb_core
// Assumes: apb slave answers when ready, link at 80 ns
// Notes:   expectations built from the word layout
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL %s exp %h got %h", n, e, g); end end
module tb
	import qdb_pkg::*;
;
	logic        clk = 1'b0, rst_n = 1'b0, pin = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic        err, pready, pslverr, scl, sda_m, sda_oe;
	logic [47:0] code;
	logic [7:0]  mode;
	logic [3:0]  act;
	int          error_cnt = 0, num_checks = 0;
	// sda wire: pull-up unless a side pulls low
	qdb_core dut (.CLOCK_I(clk), .RST_B_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .SCL_I(scl), .SDA_I(sda_m & ~sda_oe),
		.SDA_O(), .SDA_OE_O(sda_oe), .ADDRESS_SELECT_PIN_I(pin), .DAC_CODE_O(code),
		.POWER_MODE_O(mode), .OUT_ACTIVE_O(act));
	qdb_link_master lm (.clk_i(clk), .scl_o(scl), .sda_o(sda_m));
	initial forever #5 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do @(posedge clk);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic s_reset();
		`CHK("code", 48'h0, code)
		`CHK("mode", 8'h00, mode)
		`CHK("active", 4'hF, act)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, ADR_STATUS, 32'hF);
		`CHK("ro_status", 1'b1, err)
	endtask
	task automatic s_dbl();
		lm.xfer(pin, 8'h03, 16'h3123);
		`CHK("held", 48'h0, code)
		apb(1'b0, ADR_INPUT0 + 8'h4, 32'h0);
		`CHK("input1", 12'h123, rd[11:0])
		apb(1'b0, ADR_STATUS, 32'h0);
		`CHK("dirty", 4'h3, rd[3:0])
		lm.xfer(pin, 8'h04, 16'h3456);
		lm.xfer(pin, 8'h08, 16'h2789);
		`CHK("loaded", 48'h789456123123, code)
		apb(1'b0, ADR_STATUS, 32'h0);
		`CHK("clean", 4'h0, rd[3:0])
	endtask
	task automatic s_pwr();
		for (int m = 1; m < 4; m++) begin
			apb(1'b1, ADR_CMD, {12'h0, 4'h2, m[1:0], 14'h3123});
			lm.tick(3);
			`CHK("pd_mode", {4'h0, m[1:0], 2'h0}, mode)
			`CHK("pd_off", 4'hD, act)
			`CHK("kept", 48'h789456123123, code)
		end
		apb(1'b1, ADR_CMD, 32'h0002_3123);
		lm.tick(WAKE_CYC - 10);
		`CHK("waking", 4'hD, act)
		lm.tick(20);
		`CHK("awake", 4'hF, act)
	endtask
	task automatic s_clr_adr();
		lm.xfer(pin, 8'h01, 16'h1ABC);
		`CHK("cleared", 48'h0, code)
		apb(1'b0, ADR_INPUT0 + 8'hC, 32'h0);
		`CHK("in_clr", 12'h000, rd[11:0])
		pin <= 1'b1;
		lm.xfer(1'b0, 8'h01, 16'h2ABC);
		`CHK("foreign", 48'h0, code)
		lm.xfer(1'b1, 8'h01, 16'h2ABC);
		`CHK("own", 48'hABC, code)
	endtask
	initial begin
		lm.tick(6);
		rst_n <= 1'b1;
		lm.tick(4);
		s_reset();
		s_dbl();
		s_pwr();
		s_clr_adr();
		report_and_stop();
	end
endmodule
